// ---- lcc_regs.svh ----
// Register offsets, field positions, reset values and counter constants.
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH
// ******
// Register offsets (byte addresses).
// ******
`define LCC_ADDR_HCTRL 5'h00
`define LCC_ADDR_ACQ   5'h04
`define LCC_ADDR_STAT  5'h08
`define LCC_ADDR_SWCTL 5'h0c
`define LCC_ADDR_WEND  5'h10
// ******
// Field positions.
// ******
`define LCC_HOLD_LSB 0
`define LCC_CLR_LSB  3
`define LCC_JMP_LSB  6
`define LCC_STK_LSB  9
`define LCC_STEP_LSB 12
`define LCC_WBEG_LSB 15
`define LCC_CMD_LSB  0
`define LCC_MODE_LSB 2
`define LCC_TSRC_LSB 5
`define LCC_SWTR_BIT 7
`define LCC_TDLY_LSB 8
`define LCC_SWCLR_BIT 0
`define LCC_CNT_LSB  16
// ******
// Reset values and counter constants.
// ******
`define LCC_HCTRL_RST 18'h00000
`define LCC_ACQ_RST   18'h00000
`define LCC_WEND_RST  14'h07ff
`define LCC_STICK_VAL 14'h1ff0
`define LCC_JUMP_VAL  14'h2000
`define LCC_DLY_SHIFT 3
`endif

// ---- lcc_pkg.sv ----
// Types shared by the line counter and capture logic.
package lcc_pkg;
    // Capture machine states.
    typedef enum logic [1:0] {ST_IDLE, ST_SNAP, ST_GRAB, ST_STREAM} lcc_state_type;
    // Two-bit capture commands.
    typedef logic [1:0] lcc_cmd_type;
    // Three-bit event selects.
    typedef logic [2:0] lcc_sel_type;
endpackage

// ---- lcc_evt_if.sv ----
// Synchronised camera levels and their edge pulses.
`timescale 1ns/10ps
`default_nettype none
interface lcc_evt_if #(parameter int N_TRIG = 3);
    logic              line_valid;  // Line valid level.
    logic              lv_rise;     // Line valid rising pulse.
    logic              lv_fall;     // Line valid falling pulse.
    logic              fv_rise;     // Frame valid rising pulse.
    logic              fv_fall;     // Frame valid falling pulse.
    logic              encoder;     // Encoder level.
    logic              enc_rise;    // Encoder rising pulse.
    logic              enc_fall;    // Encoder falling pulse.
    logic [N_TRIG-1:0] trig;        // Hardware trigger levels.
    modport src (output line_valid, lv_rise, lv_fall, fv_rise, fv_fall,
                 output encoder, enc_rise, enc_fall, trig);
    modport dst (input line_valid, lv_rise, lv_fall, fv_rise, fv_fall,
                 input encoder, enc_rise, enc_fall, trig);
endinterface
`default_nettype wire

// ---- lcc_sync.sv ----
// Two-stage synchroniser for camera pins with edge detection.
`timescale 1ns/10ps
`default_nettype none
module lcc_sync #(
    parameter int N_TRIG = 3
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              line_valid_pin,
    input  wire logic              frame_valid_pin,
    input  wire logic              encoder_pin,
    input  wire logic [N_TRIG-1:0] trig_pin,
    lcc_evt_if.src                 evt
);
    localparam int W = N_TRIG + 3;
    logic [W-1:0] s1_r;  // First stage, read only by s2_r.
    logic [W-1:0] s2_r;  // Second stage, safe to use.
    logic [W-1:0] s3_r;  // Previous value for edges.

    // The pins are asynchronous to clk, so two flops come first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {trig_pin, encoder_pin, frame_valid_pin, line_valid_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign evt.line_valid = s2_r[0];
    assign evt.lv_rise    = s2_r[0] & ~s3_r[0];
    assign evt.lv_fall    = ~s2_r[0] & s3_r[0];
    assign evt.fv_rise    = s2_r[1] & ~s3_r[1];
    assign evt.fv_fall    = ~s2_r[1] & s3_r[1];
    assign evt.encoder    = s2_r[2];
    assign evt.enc_rise   = s2_r[2] & ~s3_r[2];
    assign evt.enc_fall   = ~s2_r[2] & s3_r[2];
    assign evt.trig       = s2_r[W-1:3];
endmodule
`default_nettype wire

// ---- lcc_trig_delay.sv ----
// Line-counted delay on the rising side of the hardware trigger.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_regs.svh"
module lcc_trig_delay #(
    parameter int DW = 10
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          trig_in,
    input  wire logic          line_tick,
    input  wire logic [DW-1:0] delay_steps,
    output logic               trig_out
);
    localparam int CW = DW + `LCC_DLY_SHIFT;
    logic [CW-1:0] lines_r;  // Lines seen since the trigger rose.
    logic [CW-1:0] target;   // Delay in lines, eight per step.

    assign target = {delay_steps, {`LCC_DLY_SHIFT{1'b0}}};

    // The output rises after the delay but falls with the input at once.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lines_r  <= '0;
            trig_out <= 1'b0;
        end else if (!trig_in) begin
            lines_r  <= '0;
            trig_out <= 1'b0;
        end else if (!trig_out) begin
            if (lines_r == target) begin
                trig_out <= 1'b1;
            end else if (line_tick) begin
                lines_r <= lines_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- lcc_top.sv ----
// Line position counter control and frame capture state machine.
// Contract
// RULE1: Six operations, each own three-bit select.
// RULE2: Encoder, line, table, software, frame events.
// RULE3: Hold select 1 waits at zero.
// RULE4: Clear at window end, frame/table, table.
// RULE5: Software clear or cancel always clears.
// RULE6: Stick select 1 holds at 1ff0h.
// RULE7: Jump to 2000h, table-column qualified.
// RULE8: Counter steps when nothing else acts.
// RULE9: Latch command, execute at frame start.
// RULE10: Only mark frames; windows size them.
// RULE11: Commands freeze, cancel, snap, grab.
// RULE12: Cancel cuts the current frame off. In mode 011b the code keeps ST_STREAM and the mark follows the trigger.
// RULE13: State field updates at frame start.
// RULE14: Command needs writing before frame start.
// RULE15: Snap start clears the command field.
// RULE16: Snap/grab during capture is ignored.
// RULE17: Mode 000b runs command next frame.
// RULE18: Mode 001b waits for trigger.
// RULE19: Host rewrites command after triggered capture.
// RULE20: Mode 010b snaps one frame per trigger.
// RULE21: Mode 011b captures while trigger high.
// RULE22: Three hardware triggers or software.
// RULE23: Hardware trigger delay, eight-line steps.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_regs.svh"
module lcc_top #(
    parameter int CW = 14,
    parameter int DW = 10
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [4:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          we,
    input  wire logic          re,
    output logic [31:0]        rdata,
    input  wire logic          line_valid,
    input  wire logic          frame_valid,
    input  wire logic          encoder,
    input  wire logic [2:0]    trig_hw,
    input  wire logic          table_clear_event,
    input  wire logic          table_jump_enable_column,
    output logic [CW-1:0]      line_position_counter,
    output logic               window_open,
    output logic               capture_mark,
    output lcc_pkg::lcc_cmd_type capture_state_field
);
    import lcc_pkg::*;

    // ******
    // Declarations.
    // ******
    lcc_evt_if #(.N_TRIG(3)) evt ();  // Synchronised camera events.
    logic [17:0]   hctrl_r;           // Six event selects.
    logic [17:0]   acq_r;             // Mode, source, delay, sw trigger.
    lcc_cmd_type   capture_command_field;  // Pending host command.
    logic [CW-1:0] wend_r;            // Last count inside the window.
    lcc_state_type state_r;           // Capture machine state.
    logic          armed_r;           // A trigger rise is pending.
    logic          trig_prev_r;       // Trigger of the last cycle.
    logic [CW-1:0] cnt_r;             // Line position count.
    lcc_sel_type   zero_hold_release_select;
    lcc_sel_type   line_counter_clear_select;
    lcc_sel_type   line_counter_jump_select;
    lcc_sel_type   stick_point_release_select;
    lcc_sel_type   line_counter_step_select;
    lcc_sel_type   horizontal_window_begin_select;
    logic [2:0]    capture_mode_select;
    logic [1:0]    trig_src;          // Trigger source select.
    logic          trig_hw_sel;       // Chosen hardware trigger.
    logic          trig_hw_dly;       // Hardware trigger after delay.
    logic          trigger;           // Selected trigger level.
    logic          trig_rise;         // Selected trigger rising.
    logic          acq_wr;            // Host writes the command register.
    lcc_cmd_type   wr_cmd;            // Command being written.
    logic          host_cancel_write; // Host writes the cancel command.
    logic          software_clear_event;
    logic          busy;              // Snap or grab in progress.
    logic          cmd_ignored;       // Snap/grab command dropped while busy.
    logic          step;              // Counter step event.
    logic          win_end;           // Last step of the window.
    logic          exec_go;           // Command runs at this frame.
    logic          cmd_clear;         // Machine clears the command.
    logic [CW-1:0] cnt_nxt;           // Next count.
    logic [7:0]    evv;               // Event vector for the selects.

    // ******
    // Event select decode.
    // ******
    // Code 0 means every clock; the rest pick one camera event.
    function automatic logic evt_hit(input lcc_sel_type sel,
                                     input logic [7:0] ev);
        evt_hit = ev[sel];
    endfunction

    assign evv = {evt.fv_rise, evt.lv_fall, evt.lv_rise, ~evt.encoder,
                  evt.encoder, evt.enc_fall, evt.enc_rise, 1'b1};  // RULE2

    // Each operation reads only its own field.
    assign zero_hold_release_select       = hctrl_r[`LCC_HOLD_LSB +: 3];  // RULE1
    assign line_counter_clear_select      = hctrl_r[`LCC_CLR_LSB +: 3];
    assign line_counter_jump_select       = hctrl_r[`LCC_JMP_LSB +: 3];
    assign stick_point_release_select     = hctrl_r[`LCC_STK_LSB +: 3];
    assign line_counter_step_select       = hctrl_r[`LCC_STEP_LSB +: 3];
    assign horizontal_window_begin_select = hctrl_r[`LCC_WBEG_LSB +: 3];
    assign capture_mode_select = acq_r[`LCC_MODE_LSB +: 3];
    assign trig_src            = acq_r[`LCC_TSRC_LSB +: 2];

    // ******
    // Input synchroniser and trigger path.
    // ******
    lcc_sync #(.N_TRIG(3)) u_sync (
        .clk             (clk),
        .rst             (rst),
        .line_valid_pin  (line_valid),
        .frame_valid_pin (frame_valid),
        .encoder_pin     (encoder),
        .trig_pin        (trig_hw),
        .evt             (evt.src)
    );

    // Source 3 is the software bit; it bypasses the delay.
    assign trig_hw_sel = (trig_src == 2'd3) ? 1'b0 : evt.trig[trig_src];  // RULE22

    lcc_trig_delay #(.DW(DW)) u_dly (
        .clk         (clk),
        .rst         (rst),
        .trig_in     (trig_hw_sel),
        .line_tick   (evt.lv_rise),
        .delay_steps (acq_r[`LCC_TDLY_LSB +: DW]),
        .trig_out    (trig_hw_dly)
    );  // RULE23

    assign trigger   = (trig_src == 2'd3) ? acq_r[`LCC_SWTR_BIT] : trig_hw_dly;
    assign trig_rise = trigger & ~trig_prev_r;

    // Previous trigger level for the edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trigger;
        end
    end

    // ******
    // Register writes.
    // ******
    assign acq_wr               = we && (addr == `LCC_ADDR_ACQ);
    assign wr_cmd               = wdata[`LCC_CMD_LSB +: 2];
    assign host_cancel_write    = acq_wr && (wr_cmd == 2'b01);
    assign software_clear_event = we && (addr == `LCC_ADDR_SWCTL) &&
                                  wdata[`LCC_SWCLR_BIT];
    assign busy        = (state_r == ST_SNAP) || (state_r == ST_GRAB);
    assign cmd_ignored = busy && wr_cmd[1];  // RULE16

    // Configuration registers written by software.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hctrl_r <= `LCC_HCTRL_RST;
            acq_r   <= `LCC_ACQ_RST;
            wend_r  <= `LCC_WEND_RST;
        end else if (we) begin
            if (addr == `LCC_ADDR_HCTRL) begin
                hctrl_r <= wdata[17:0];
            end
            if (acq_wr) begin
                acq_r <= wdata[17:0];
            end
            if (addr == `LCC_ADDR_WEND) begin
                wend_r <= wdata[CW-1:0];
            end
        end
    end

    // Host sets the command; the machine clears it. A write in the
    // clearing cycle wins unless it is a snap/grab dropped while busy.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_command_field <= 2'b00;
        end else if (acq_wr && !cmd_ignored) begin
            capture_command_field <= wr_cmd;  // RULE9 RULE14
        end else if (cmd_clear) begin
            capture_command_field <= 2'b00;  // RULE15
        end
    end

    // ******
    // Line position counter.
    // ******
    assign step    = evt_hit(line_counter_step_select, evv);
    assign win_end = window_open && step && (cnt_r == wend_r);

    // Priority: forced clear, selected clear, jump, waits, step.
    always_comb begin
        cnt_nxt = cnt_r;
        if (software_clear_event || host_cancel_write) begin
            cnt_nxt = '0;  // RULE5
        end else if ((line_counter_clear_select == 3'd0 && win_end) ||
                     (line_counter_clear_select == 3'd1 &&
                      (evt.fv_rise || table_clear_event)) ||
                     (line_counter_clear_select == 3'd2 && table_clear_event)) begin
            cnt_nxt = '0;  // RULE4
        end else if (table_jump_enable_column &&
                     ((line_counter_jump_select == 3'd1 && evt.lv_rise) ||
                      (line_counter_jump_select == 3'd2 && evt.enc_rise))) begin
            cnt_nxt = `LCC_JUMP_VAL;  // RULE7
        end else if (zero_hold_release_select == 3'd1 && cnt_r == '0 &&
                     !evt.enc_rise) begin
            cnt_nxt = cnt_r;  // RULE3
        end else if (stick_point_release_select == 3'd1 &&
                     cnt_r == `LCC_STICK_VAL) begin
            cnt_nxt = cnt_r;  // RULE6
        end else if (step) begin
            cnt_nxt = cnt_r + 1'b1;  // RULE8
        end
    end

    // Counter state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Window opens on its own begin event and closes at wend_r.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            window_open <= 1'b0;
        end else if (win_end) begin
            window_open <= 1'b0;
        end else if (evt_hit(horizontal_window_begin_select, evv)) begin
            window_open <= 1'b1;  // RULE1
        end
    end

    assign line_position_counter = cnt_r;

    // ******
    // Capture state machine.
    // ******
    // Snap and grab run in mode 0 at the next frame start, in mode 1 only after a
    // trigger; a grab already running needs no fresh trigger.
    always_comb begin
        exec_go   = 1'b0;
        cmd_clear = 1'b0;
        if (evt.fv_rise && !host_cancel_write) begin
            unique case (capture_mode_select)
                3'd0: exec_go = capture_command_field[1];  // RULE17
                3'd1: exec_go = capture_command_field[1] && armed_r;  // RULE18
                3'd2: exec_go = (capture_command_field == 2'b11) && armed_r;  // RULE20
                default: exec_go = 1'b0;
            endcase
            cmd_clear = exec_go && (capture_command_field == 2'b10) &&
                        (capture_mode_select != 3'd2);  // RULE15 RULE19
        end
    end

    // A trigger rise waits here until a frame start uses it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (trig_rise) begin
            armed_r <= 1'b1;
        end else if (exec_go) begin
            armed_r <= 1'b0;
        end
    end

    // State changes only at frame start, except cancel and mode 3.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else if (capture_mode_select == 3'd3) begin
            state_r <= ST_STREAM;  // RULE21
        end else if (host_cancel_write) begin
            state_r <= ST_IDLE;  // RULE12
        end else if (evt.fv_rise) begin
            if (state_r == ST_GRAB && capture_command_field == 2'b11 &&
                capture_mode_select != 3'd2) begin
                state_r <= ST_GRAB;
            end else if (exec_go) begin
                state_r <= (capture_command_field == 2'b11 &&
                            capture_mode_select != 3'd2) ? ST_GRAB : ST_SNAP;  // RULE11
            end else begin
                state_r <= ST_IDLE;  // RULE13
            end
        end
    end

    // Frame mark: set by the state at frame start, cleared at frame
    // end; in mode 3 it follows the trigger. Pixel and line extent come from the capture windows.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_mark <= 1'b0;
        end else if (capture_mode_select == 3'd3) begin
            capture_mark <= trigger;  // RULE21
        end else if (host_cancel_write || evt.fv_fall) begin
            capture_mark <= 1'b0;  // RULE12 RULE10
        end else if (evt.fv_rise) begin
            capture_mark <= exec_go || (state_r == ST_GRAB &&
                            capture_command_field == 2'b11 &&
                            capture_mode_select != 3'd2);  // RULE10
        end
    end

    // State field shows the command in progress.
    always_comb begin
        unique case (state_r)
            ST_IDLE:   capture_state_field = 2'b00;
            ST_SNAP:   capture_state_field = 2'b10;
            ST_GRAB:   capture_state_field = 2'b11;
            ST_STREAM: capture_state_field = 2'b11;
        endcase
    end

    // ******
    // Register reads, data one cycle after the strobe.
    // ******
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (re) begin
            unique case (addr)
                `LCC_ADDR_HCTRL: rdata <= {14'h0000, hctrl_r};
                `LCC_ADDR_ACQ:   rdata <= {14'h0000, acq_r[17:2],
                                           capture_command_field};
                `LCC_ADDR_STAT:  rdata <= {2'h0, cnt_r, 11'h000, trigger,
                                           window_open, capture_mark,
                                           capture_state_field};
                `LCC_ADDR_WEND:  rdata <= {18'h00000, wend_r};
                default:         rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- lcc_top_assertions.sv ----
// Port-level assertions for the line counter and capture machine.
`timescale 1ns/10ps
`default_nettype none
module lcc_top_assertions #(
    parameter int CW = 14,
    parameter int DW = 10
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [4:0]           addr,
    input wire logic [31:0]          wdata,
    input wire logic                 we,
    input wire logic                 re,
    input wire logic [31:0]          rdata,
    input wire logic                 frame_valid,
    input wire logic                 encoder,
    input wire logic                 table_clear_event,
    input wire logic [CW-1:0]        line_position_counter,
    input wire logic                 capture_mark,
    input wire lcc_pkg::lcc_cmd_type capture_state_field
);
    import lcc_pkg::*;
    logic [17:0] hctrl_r; // Copy of the select word.
    wire logic   cancel_w = we && addr == 5'h04 && wdata[1:0] == 2'h1 && wdata[4:2] != 3'h3;
    wire logic   swclr_w = we && addr == 5'h0c && wdata[0];
    // Follows host writes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hctrl_r <= 18'h00000;
        end else if (we && addr == 5'h00) begin
            hctrl_r <= wdata[17:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    read_idle_a:
        assert property (!$past(re) |-> rdata == 32'h0) else $error("stale read data");
    status_read_a:
        assert property (re && addr == 5'h08 |=> rdata[1:0] == $past(capture_state_field)
            && rdata[29:16] == $past(line_position_counter)) else $error("bad status");
    unmapped_read_a:
        assert property (re && addr inside {5'h0c, 5'h14} |=> rdata == 32'h0) else $error("hole");
    cancel_stop_a:
        assert property (cancel_w |=> !capture_mark && capture_state_field == 2'h0)
            else $error("no stop");
    clear_always_a:
        assert property (cancel_w || swclr_w |=> line_position_counter == '0)
            else $error("no clear");
    state_code_a:
        assert property (capture_state_field != 2'h1) else $error("bad state code");
    snap_start_a:
        assert property ($rose(capture_mark) && capture_state_field == 2'h2
            |-> $past(frame_valid, 2)) else $error("snap outside frame");
    stick_hold_a:
        assert property (hctrl_r[11:9] == 3'h1 && line_position_counter == 14'h1ff0 && !we
            |=> line_position_counter inside {14'h1ff0, 14'h0, 14'h2000}) else $error("slip");
    table_clear_a:
        assert property (hctrl_r[5:3] == 3'h2 && table_clear_event |=> line_position_counter == '0)
            else $error("table clear missed");
    zero_hold_a:
        assert property (hctrl_r[2:0] == 3'h1 && $past(line_position_counter) == '0
            && line_position_counter == 14'h1 |-> $past(encoder, 3)) else $error("left zero");
    cover property (capture_state_field == 2'h2);
    cover property (capture_state_field == 2'h3 && capture_mark);
    cover property (line_position_counter == 14'h1ff0);
endmodule
bind lcc_top lcc_top_assertions #(.CW(CW), .DW(DW)) u_chk (.*);
`default_nettype wire

// ---- lcc_cam_model.sv ----
// Camera timing model: frames of 300 cycles in a 400-cycle period.
`timescale 1ns/10ps
`default_nettype none
module lcc_cam_model (
    input wire logic clk,
    input wire logic rst,
    output logic     frame_valid,
    output logic     line_valid,
    output logic     encoder
);
    int cnt_r; // Position within the frame period.
    // Free-running period counter; levels change just after an edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= (cnt_r == 399) ? 0 : cnt_r + 1;
        end
    end
    // Lines last 12 of every 20 cycles; the encoder stands still low between frames.
    assign frame_valid = cnt_r >= 20 && cnt_r < 320;
    assign line_valid = frame_valid && (cnt_r % 20) < 12;
    assign encoder = frame_valid && (cnt_r % 10) < 5;
endmodule
`default_nettype wire

// ---- tb_line_counter_and_capture_fsm.sv ----
// Self-checking bench for the line counter and capture machine.
`timescale 1ns/10ps
`default_nettype none
module tb_line_counter_and_capture_fsm;
    import lcc_pkg::*;
    logic        clk = 0, rst = 1, we = 0, re = 0, tce = 0, tje = 0, fv, lv, enc, wo, mark;
    logic [4:0]  addr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [2:0]  trig = 0;
    logic [13:0] lpc;
    lcc_cmd_type st;
    int          seed = 92906, num_errors = 0, cmp_count = 0, m_cmd = 0, m_st = 0, k, mx;
    int          cmds[6] = '{2, 3, 3, 2, 0, 3}, tm[2] = '{'h66, 'h6b};
    always #4 clk = ~clk;
    lcc_cam_model cam (.clk(clk), .rst(rst), .frame_valid(fv), .line_valid(lv), .encoder(enc));
    lcc_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .line_valid(lv), .frame_valid(fv), .encoder(enc), .trig_hw(trig),
        .table_clear_event(tce), .table_jump_enable_column(tje), .line_position_counter(lpc),
        .window_open(wo), .capture_mark(mark), .capture_state_field(st));
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        addr <= a; re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    // Status check: mark and state against the model.
    task automatic chst();
        rd(5'h08);
        chk(32'(d[2:0]), 32'({m_st != 0, 2'(m_st)}));
    endtask
    // Host model: snap/grab dropped while busy; cancel stops at once.
    function automatic void m_wr(int c);
        if (!(c >= 2 && m_st >= 2)) m_cmd = c;
        if (c == 1) m_st = 0;
    endfunction
    // Frame start: a snap runs once and clears the command.
    function automatic void m_frame();
        m_st = (m_cmd >= 2) ? m_cmd : 0;
        if (m_cmd == 2) m_cmd = 0;
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rchk(5'h10, 32'h7ff);
        rchk(5'h14, 0);
        rchk(5'h0c, 0);
        rd(5'h08);
        chk(d & 32'hc000fff7, 0);
        k = $random(seed) & 32'h3ffff;
        wr(5'h00, 32'(k));
        rchk(5'h00, 32'(k));
        wr(5'h00, 0);
        foreach (cmds[i]) begin
            @(negedge fv);
            wr(5'h04, 32'(cmds[i]));
            m_wr(cmds[i]);
            rchk(5'h04, 32'(m_cmd));
            @(posedge fv);
            repeat (6) @(posedge clk);
            m_frame();
            chst();
            rchk(5'h04, 32'(m_cmd));
        end
        repeat (20) @(posedge clk);
        wr(5'h04, 1);
        m_wr(1);
        chst();
        // Software trigger, mode 1 then 2: one snap per trigger.
        foreach (tm[i]) begin
            @(negedge fv);
            wr(5'h04, 32'(tm[i]));
            wr(5'h04, 32'(tm[i] | 'h80));
            wr(5'h04, 32'(tm[i]));
            @(posedge fv);
            repeat (6) @(posedge clk);
            m_st = 2;
            chst();
            rchk(5'h04, 32'(tm[i] - (i ? 0 : 2)));
            @(posedge fv);
            repeat (6) @(posedge clk);
            m_st = 0;
            chst();
        end
        // Mode 3 on a random hardware trigger delayed by one eight-line step.
        k = {$random(seed)} % 3;
        wr(5'h04, 32'(32'h10c | (k << 5)));
        trig[k] <= 1'b1;
        repeat (4) @(posedge lv);
        #1 chk(32'(mark), 0);
        repeat (8) @(posedge lv);
        repeat (6) @(posedge clk);
        m_st = 3;
        chst();
        trig <= 3'h0;
        repeat (10) @(posedge clk);
        #1 chk(32'(mark), 0);
        // Window-end clear with a random window and hold at zero until an encoder rise.
        k = 16 + {$random(seed)} % 48;
        wr(5'h10, 32'(k));
        wr(5'h00, 1);
        wr(5'h0c, 1);
        mx = 0;
        repeat (800) begin
            @(posedge clk);
            #1 if (int'(lpc) > mx) mx = int'(lpc);
        end
        chk(32'(mx), 32'(k));
        @(negedge fv);
        repeat (80) @(posedge clk);
        #1 chk(32'(lpc), 0);
        // Stick point, then table-qualified jump and table clear.
        wr(5'h00, 32'h250);
        wr(5'h0c, 1);
        repeat (8300) @(posedge clk);
        #1 chk(32'(lpc), 32'h1ff0);
        tje <= 1'b1;
        @(posedge lv);
        repeat (6) @(posedge clk);
        #1 chk(32'(lpc[13:4]), 32'h200);
        @(posedge clk);
        tce <= 1'b1;
        @(posedge clk);
        tce <= 1'b0;
        #1 chk(32'(lpc), 0);
        final_report();
    end
endmodule
`default_nettype wire
